// ===== pkg/tecb_pkg.sv
// constants, types and register map of the timer/event counter with buzzer
// Contract
// - mode field picks none, event, timer, pulse
// - clock source bit picks sysclk/4 or aux
// - count enable bit runs or holds counter
// - prescaler divides by one up to 128
// - timer mode counts prescaled clock falling edges
// - timer overflow requests interrupt and reloads
// - event mode clocks from pin, no prescaler
// - edge select picks rising or falling events
// - event counting and wake-up while powered down
// - pulse mode enable only arms the counter
// - edge low: falling starts, rising stops
// - edge high: rising starts, falling stops
// - after measurement hold value, ignore pin
// - timer and event modes never self-clear enable
// - pulse mode overflow requests, reloads, continues
// - buzzer toggles on selected timer overflow
// - inverted buzzer pin is inverse of first
// - port data bit 1 gates both buzzer pins
// - port data bit 2 ignored on inverted pin
// - direction bit high makes pin an input
// - only first buzzer selected, second is port
// - count from loaded value to all ones
// - overflow sets own request flag
// - low byte buffered, high write loads both
package tecb_pkg;

    // register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_CNT_LO = 3'h1;
    localparam logic [2:0] ADDR_CNT_HI = 3'h2;
    localparam logic [2:0] ADDR_MISC = 3'h3;
    localparam logic [2:0] ADDR_PFS = 3'h4;
    localparam logic [2:0] ADDR_DIR = 3'h5;
    localparam logic [2:0] ADDR_DATA = 3'h6;
    localparam logic [2:0] ADDR_STAT = 3'h7;

    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [1:0] DIR_RESET = 2'h3;
    localparam logic [1:0] DATA_RESET = 2'h0;
    localparam logic [1:0] PFS_RESET = 2'h0;

    // field positions
    localparam int STAT_FLAG_BIT = 0;
    localparam int MISC_BZSRC_BIT = 0;
    localparam int PFS_BZ_BIT = 0;
    localparam int PFS_BZINV_BIT = 1;

    // system clock divider for the internal timer source
    localparam int CLK_HZ = 20_000_000;
    localparam int SYS_DIV = 4;
    localparam logic [1:0] SYS_DIV_LAST = 2'(SYS_DIV - 1);

    typedef enum logic [1:0]
    {
        MODE_NONE = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PULSE = 2'h3
    } tecb_mode_e;

    typedef struct packed
    {
        tecb_mode_e mode_select_field;
        logic clock_source_select;
        logic count_enable;
        logic active_edge_select;
        logic [2:0] prescale_select_field;
    } tecb_ctrl_s;

    // pulse width measurement states, gray along idle-armed-count
    typedef enum logic [1:0]
    {
        PW_IDLE = 2'b00,
        PW_ARMED = 2'b01,
        PW_COUNT = 2'b11
    } tecb_pw_e;

endpackage

// ===== rtl/tecb_sync.sv
// two-flop synchroniser with edge detection for asynchronous pins
`timescale 1ns/100ps
module tecb_sync #(
    parameter int W = 1
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // asynchronous inputs
    input wire logic [W-1:0] async_in,
    // synchronised level and edge pulses
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] meta;
    logic [W-1:0] prev;

    // meta feeds only level; edges compare level against its delayed copy
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            meta <= '0;
            level <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= async_in;
            level <= meta;
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule

// ===== rtl/tecb_prescaler.sv
// power-of-two prescaler driven by a one-cycle tick
`timescale 1ns/100ps
module tecb_prescaler #(
    parameter int STAGES = 7
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // source tick and control
    input wire logic tick_in,
    input wire logic clear,
    input wire logic [2:0] sel,
    // divided tick
    output logic tick_out
);

    logic [STAGES-1:0] count;
    logic [STAGES-1:0] mask;

    // the divided clock falls when the low sel bits all roll over
    assign mask = STAGES'((8'h01 << sel) - 8'h01);
    assign tick_out = tick_in && ((count & mask) == mask);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (tick_in)
            count <= count + STAGES'(1);
    end

endmodule

// ===== rtl/tecb_top.sv
// timer/event counter with pulse width mode and buzzer pin pair
`timescale 1ns/100ps
module tecb_top #(
    parameter int CNT_W = 16
)(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // timer pins and clock sources
    input wire logic timer_input_pin,
    input wire logic aux_timer_clock,
    // system state and sibling timers
    input wire logic power_down,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    // events
    output logic overflow_pulse,
    output logic overflow_request_flag,
    output logic wake_up,
    // buzzer pin pair, shared with port pins
    input wire logic pa1_in,
    output logic pa1_out,
    output logic pa1_oe,
    input wire logic pa2_in,
    output logic pa2_out,
    output logic pa2_oe
);

    // registers
    tecb_pkg::tecb_ctrl_s timer2_control;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] preload;
    logic [7:0] low_buffer;
    logic buzzer_source_select;
    logic buzzer_pin_select;
    logic inverted_buzzer_pin_select;
    logic port_dir_bit1;
    logic port_dir_bit2;
    logic port_data_bit1;
    logic port_data_bit2;
    logic buzzer_out;
    logic [1:0] sys_div;
    tecb_pkg::tecb_pw_e pw_state;
    tecb_pkg::tecb_pw_e next_pw_state;

    // synchronised pins
    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    tecb_sync #(
        .W(4)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in({pa2_in, pa1_in, aux_timer_clock, timer_input_pin}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // register decode
    wire wr_ctrl = reg_wr && (reg_addr == tecb_pkg::ADDR_CTRL);
    wire wr_lo = reg_wr && (reg_addr == tecb_pkg::ADDR_CNT_LO);
    wire wr_hi = reg_wr && (reg_addr == tecb_pkg::ADDR_CNT_HI);
    wire wr_misc = reg_wr && (reg_addr == tecb_pkg::ADDR_MISC);
    wire wr_pfs = reg_wr && (reg_addr == tecb_pkg::ADDR_PFS);
    wire wr_dir = reg_wr && (reg_addr == tecb_pkg::ADDR_DIR);
    wire wr_data = reg_wr && (reg_addr == tecb_pkg::ADDR_DATA);
    wire wr_stat = reg_wr && (reg_addr == tecb_pkg::ADDR_STAT);
    wire rd_hi = reg_rd && (reg_addr == tecb_pkg::ADDR_CNT_HI);

    // control fields
    wire count_enable = timer2_control.count_enable;
    wire active_edge_select = timer2_control.active_edge_select;
    wire is_event =
        timer2_control.mode_select_field == tecb_pkg::MODE_EVENT;
    wire is_timer =
        timer2_control.mode_select_field == tecb_pkg::MODE_TIMER;
    wire is_pulse =
        timer2_control.mode_select_field == tecb_pkg::MODE_PULSE;

    // internal clock source: system clock over four or the aux clock
    // the divider runs free, so a first tick may come up to four clocks late
    // aux is counted on synchronised falls, so keep it well below clk/2
    wire sys_tick = (sys_div == tecb_pkg::SYS_DIV_LAST);
    wire aux_tick = pin_fall[1];
    wire src_tick = timer2_control.clock_source_select ?
        aux_tick : sys_tick;
    wire pre_tick;

    // prescaler restarts while the counter is off, so a new run is aligned
    tecb_prescaler #(
        .STAGES(7)
    ) u_presc (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick_in(src_tick),
        .clear(!count_enable),
        .sel(timer2_control.prescale_select_field),
        .tick_out(pre_tick)
    );

    // pin edges for event and pulse modes
    // a pin edge is seen two clocks late; each level needs two clocks
    wire pin_r = pin_rise[0];
    wire pin_f = pin_fall[0];
    wire event_edge = active_edge_select ? pin_f : pin_r;
    wire pw_start = active_edge_select ? pin_r : pin_f;
    wire pw_stop = active_edge_select ? pin_f : pin_r;
    wire pw_counting = (pw_state == tecb_pkg::PW_COUNT);
    wire pw_done = pw_counting && pw_stop;

    // count tick per mode; the event pin bypasses the prescaler
    wire tick_event = is_event && count_enable && event_edge;
    wire tick_timer = is_timer && count_enable && pre_tick;
    wire tick_pulse = pw_counting && pre_tick && !pw_stop;
    wire count_tick = tick_event || tick_timer || tick_pulse;

    // overflow at all ones, in every counting mode
    // the counter reloads on overflow, it never wraps through zero
    wire count_full = (count == {CNT_W{1'b1}});
    wire overflow = count_tick && count_full;

    // pulse width measurement sequencing
    always_comb
    begin
        next_pw_state = pw_state;
        case (pw_state)
            tecb_pkg::PW_IDLE:
            begin
                if (is_pulse && count_enable)
                    next_pw_state = tecb_pkg::PW_ARMED;
            end
            tecb_pkg::PW_ARMED:
            begin
                if (!is_pulse || !count_enable)
                    next_pw_state = tecb_pkg::PW_IDLE;
                else if (pw_start)
                    next_pw_state = tecb_pkg::PW_COUNT;
            end
            tecb_pkg::PW_COUNT:
            begin
                if (pw_stop || !is_pulse || !count_enable)
                    next_pw_state = tecb_pkg::PW_IDLE;
            end
            default:
                next_pw_state = tecb_pkg::PW_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            pw_state <= tecb_pkg::PW_IDLE;
        else
            pw_state <= next_pw_state;
    end

    // control register; only pulse mode clears the enable by itself
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            timer2_control <= tecb_pkg::CTRL_RESET;
        else if (wr_ctrl)
            timer2_control <= reg_wdata;
        else if (pw_done && is_pulse)
            timer2_control.count_enable <= 1'b0;
    end

    // system clock divider
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            sys_div <= 2'h0;
        else
            sys_div <= sys_div + 2'h1;
    end

    // counter, preload and low-byte buffer
    wire [CNT_W-1:0] hi_load = CNT_W'({reg_wdata, low_buffer});
    wire [CNT_W-1:0] count_inc = count + CNT_W'(1);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            preload <= '0;
        else if (wr_hi)
            preload <= hi_load;
    end

    // a high-byte write also restarts the counter from the new value
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count <= '0;
        else if (wr_hi)
            count <= hi_load;
        else if (overflow)
            count <= preload;
        else if (count_tick)
            count <= count_inc;
    end

    // reading the high byte snapshots the low byte for a coherent pair
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            low_buffer <= 8'h00;
        else if (wr_lo)
            low_buffer <= reg_wdata;
        else if (rd_hi)
            low_buffer <= count[7:0];
    end

    // request flag: set beats a same-cycle write-one clear
    wire flag_clear = wr_stat && reg_wdata[tecb_pkg::STAT_FLAG_BIT];
    wire next_flag = overflow || (overflow_request_flag && !flag_clear);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            overflow_request_flag <= 1'b0;
            overflow_pulse <= 1'b0;
            wake_up <= 1'b0;
        end
        else
        begin
            overflow_request_flag <= next_flag;
            overflow_pulse <= overflow;
            wake_up <= overflow && power_down;
        end
    end

    // buzzer and port registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            buzzer_source_select <= 1'b0;
            {inverted_buzzer_pin_select, buzzer_pin_select} <=
                tecb_pkg::PFS_RESET;
            {port_dir_bit2, port_dir_bit1} <= tecb_pkg::DIR_RESET;
            {port_data_bit2, port_data_bit1} <= tecb_pkg::DATA_RESET;
        end
        else
        begin
            if (wr_misc)
                buzzer_source_select <= reg_wdata[tecb_pkg::MISC_BZSRC_BIT];
            if (wr_pfs)
                {inverted_buzzer_pin_select, buzzer_pin_select} <=
                    reg_wdata[1:0];
            if (wr_dir)
                {port_dir_bit2, port_dir_bit1} <= reg_wdata[1:0];
            if (wr_data)
                {port_data_bit2, port_data_bit1} <= reg_wdata[1:0];
        end
    end

    // buzzer: half the overflow rate of the selected sibling timer
    // sibling overflows are one-clock pulses, so each toggles once
    wire bz_src = buzzer_source_select ?
        timer1_overflow : timer0_overflow;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            buzzer_out <= 1'b0;
        else if (bz_src)
            buzzer_out <= !buzzer_out;
    end

    // pin muxing; the complementary pin needs both functions selected
    wire buzzer_out_inverted = !buzzer_out;
    wire pa2_is_bz = inverted_buzzer_pin_select && buzzer_pin_select;
    wire bz_on = buzzer_out && port_data_bit1;
    wire bzi_on = buzzer_out_inverted && port_data_bit1;
    wire next_pa1_out = buzzer_pin_select ? bz_on : port_data_bit1;
    wire next_pa2_out = pa2_is_bz ? bzi_on : port_data_bit2;
    wire next_pa1_oe = !port_dir_bit1;
    wire next_pa2_oe = !port_dir_bit2;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pa1_out <= 1'b0;
            pa2_out <= 1'b0;
            pa1_oe <= 1'b0;
            pa2_oe <= 1'b0;
        end
        else
        begin
            pa1_out <= next_pa1_out;
            pa2_out <= next_pa2_out;
            pa1_oe <= next_pa1_oe;
            pa2_oe <= next_pa2_oe;
        end
    end

    // read mux; data stands only in the cycle after the read strobe
    // status pin levels are the synchronised copies, two clocks behind
    wire [7:0] stat_value = {4'h0, pw_counting, pin_level[3], pin_level[2],
        overflow_request_flag};
    logic [7:0] rd_mux;

    always_comb
    begin
        case (reg_addr)
            tecb_pkg::ADDR_CTRL: rd_mux = timer2_control;
            tecb_pkg::ADDR_CNT_LO: rd_mux = low_buffer;
            tecb_pkg::ADDR_CNT_HI: rd_mux = count[CNT_W-1:CNT_W-8];
            tecb_pkg::ADDR_MISC: rd_mux = {7'h00, buzzer_source_select};
            tecb_pkg::ADDR_PFS:
                rd_mux = {6'h00, inverted_buzzer_pin_select,
                    buzzer_pin_select};
            tecb_pkg::ADDR_DIR: rd_mux = {6'h00, port_dir_bit2, port_dir_bit1};
            tecb_pkg::ADDR_DATA:
                rd_mux = {6'h00, port_data_bit2, port_data_bit1};
            tecb_pkg::ADDR_STAT: rd_mux = stat_value;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
        else
            reg_rdata <= 8'h00;
    end

endmodule

// ===== testbench/tecb_sva.sv
// port assertions for the timer/event counter with buzzer
`timescale 1ns/100ps
module tecb_sva (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register writes and system inputs
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic power_down,
    input wire logic timer0_overflow,
    input wire logic timer1_overflow,
    // events and pins
    input wire logic overflow_pulse,
    input wire logic overflow_request_flag,
    input wire logic wake_up,
    input wire logic pa1_out,
    input wire logic pa1_oe,
    input wire logic pa2_out,
    input wire logic pa2_oe
);
    wire clr = reg_wr && reg_addr == tecb_pkg::ADDR_STAT && reg_wdata[0];
    wire src = reg_wr || timer0_overflow || timer1_overflow;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_flag_cause: assert property ($rose(overflow_request_flag)
        |-> overflow_pulse) else $error("flag set without overflow");
    a_flag_set: assert property (overflow_pulse
        |-> overflow_request_flag) else $error("overflow left flag low");
    a_flag_hold: assert property ($past(overflow_request_flag)
        && !$past(clr) |-> overflow_request_flag)
        else $error("flag dropped without clear");
    a_flag_clear: assert property ($past(clr) && !overflow_pulse
        |-> !overflow_request_flag) else $error("flag clear ignored");
    a_wake_pd: assert property (overflow_pulse && $past(power_down)
        |-> wake_up) else $error("no wake-up in power-down");
    a_wake_only: assert property (wake_up
        |-> overflow_pulse && $past(power_down)) else $error("stray wake");
    a_ovf_once: assert property (overflow_pulse
        |=> !overflow_pulse) else $error("overflow pulse too long");
    a_pin_cause: assert property ($changed({pa1_out, pa2_out})
        |-> $past(src, 2)) else $error("pin moved without cause");
    a_dir_cause: assert property ($changed({pa1_oe, pa2_oe})
        |-> $past(reg_wr, 2)) else $error("enable moved without write");
    c_wake: cover property (wake_up);
    c_ovf: cover property (overflow_pulse && !power_down);
    c_oe: cover property ($rose(pa1_oe));
endmodule

// ===== testbench/tecb_far_end.sv
// far side: pulse source on the timer pin and a passive piezo load
`timescale 1ns/100ps
module tecb_far_end (
    // clock
    input wire logic clk,
    // pulse request from the bench
    input wire logic go,
    input wire logic lvl,
    input wire logic [15:0] width,
    // pin pair as driven by the block
    input wire logic pa1_out,
    input wire logic pa1_oe,
    input wire logic pa2_out,
    input wire logic pa2_oe,
    // levels seen at the pins
    output logic timer_input_pin,
    output logic aux_timer_clock,
    output logic pa1_in,
    output logic pa2_in
);
    // the piezo load pulls a released pin low
    assign pa1_in = pa1_oe ? pa1_out : 1'b0;
    assign pa2_in = pa2_oe ? pa2_out : 1'b0;
    // aux source runs free, phase unrelated to clk
    always
    begin
        aux_timer_clock = 1'b0;
        #170;
        aux_timer_clock = 1'b1;
        #170;
    end
    // edges land off the clock edge, the pin is asynchronous
    initial
    begin
        timer_input_pin = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                #7 timer_input_pin = lvl;
                if (width != 16'h0000)
                begin
                    repeat (width) @(posedge clk);
                    #7 timer_input_pin = ~lvl;
                end
            end
        end
    end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the timer/event counter with buzzer pins
`timescale 1ns/100ps
module testbench;
    typedef struct packed
    {
        logic [7:0] data;
        logic [7:0] mask;
    } tecb_exp_s;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic power_down = 1'b0;
    logic timer0_overflow = 1'b0;
    logic timer1_overflow = 1'b0;
    logic go = 1'b0;
    logic lvl = 1'b0;
    logic [15:0] width = 16'h0000;
    logic [7:0] reg_rdata, got;
    logic overflow_pulse, overflow_request_flag, wake_up;
    logic timer_input_pin, aux_timer_clock;
    logic pa1_in, pa1_out, pa1_oe, pa2_in, pa2_out, pa2_oe;
    logic rd_d = 1'b0;
    logic [15:0] cnt;
    logic [31:0] r;
    tecb_exp_s exp_q[$];
    tecb_exp_s e;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_ovf = 0;
    int n_wake = 0;
    int g, t0, c0;

    always #25 clk = ~clk;
    tecb_top u_tecb_top (.*);
    tecb_far_end u_tecb_far_end (.*);

    task automatic test_done();
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] gv, input logic [15:0] xv);
        n_compared++;
        if (gv !== xv)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, gv, xv);
        end
    endtask

    // one idle cycle after each strobe keeps every drive single per step
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] d,
        input logic [7:0] m);
        exp_q.push_back('{d, m});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic wr16(input logic [15:0] v);
        wr(tecb_pkg::ADDR_CNT_LO, v[7:0]);
        wr(tecb_pkg::ADDR_CNT_HI, v[15:8]);
    endtask

    task automatic rd16(input logic [15:0] d, input logic [15:0] m);
        rd(tecb_pkg::ADDR_CNT_HI, d[15:8], m[15:8]);
        cnt[15:8] = got;
        rd(tecb_pkg::ADDR_CNT_LO, d[7:0], m[7:0]);
        cnt[7:0] = got;
    endtask

    task automatic pulse(input logic l, input logic [15:0] w);
        go <= 1'b1;
        lvl <= l;
        width <= w;
        @(posedge clk);
        go <= 1'b0;
        repeat (w + 16'h0010) @(posedge clk);
    endtask

    task automatic sib(input logic s);
        timer0_overflow <= !s;
        timer1_overflow <= s;
        @(posedge clk);
        timer0_overflow <= 1'b0;
        timer1_overflow <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pins(input logic [3:0] x);
        @(posedge clk);
        #1 chk(16'({pa1_oe, pa2_oe, pa1_out, pa2_out}), 16'(x));
        @(posedge clk);
    endtask

    task automatic ovf_gap(output int gap);
        int k;
        k = n_ovf;
        while (n_ovf == k)
            @(posedge clk);
        t0 = cyc;
        k = n_ovf;
        while (n_ovf == k)
            @(posedge clk);
        gap = cyc - t0;
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rd_d <= reg_rd;
        n_ovf <= n_ovf + int'(overflow_pulse === 1'b1);
        n_wake <= n_wake + int'(wake_up === 1'b1);
        if (rd_d)
        begin
            e = exp_q.pop_front();
            got = reg_rdata;
            chk(16'(reg_rdata & e.mask), 16'(e.data & e.mask));
        end
        if (cyc == 40000)
        begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            test_done();
        end
    end

    initial
    begin
        void'($urandom(44));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 8; a++)
            rd(3'(a), a == 5 ? 8'h03 : (a == 0 ? 8'h08 : 8'h00),
                8'hff);
        pins(4'h0);
        // mode none must leave a loaded count untouched
        repeat (3)
        begin
            r = $urandom;
            wr(tecb_pkg::ADDR_CTRL, {2'h0, r[21:16]});
            rd(tecb_pkg::ADDR_CTRL, {2'h0, r[21:16]}, 8'hff);
            wr(tecb_pkg::ADDR_CNT_LO, r[7:0]);
            rd(tecb_pkg::ADDR_CNT_LO, r[7:0], 8'hff);
            wr(tecb_pkg::ADDR_CNT_HI, r[15:8]);
            repeat (20) @(posedge clk);
            rd16(r[15:0], 16'hffff);
        end
        for (int p = 0; p < 8; p++)
        begin
            wr16(16'hfffc);
            wr(tecb_pkg::ADDR_CTRL, {5'b10010, 3'(p)});
            ovf_gap(g);
            chk(16'(g), 16'(16 << p));
            rd(tecb_pkg::ADDR_CTRL, {5'b10010, 3'(p)}, 8'hff);
        end
        wr(tecb_pkg::ADDR_CTRL, 8'hb0);
        ovf_gap(g);
        chk(16'(g >= 26 && g <= 29), 16'h0001);
        wr(tecb_pkg::ADDR_CTRL, 8'ha0);
        rd16(16'h0000, 16'h0000);
        repeat (40) @(posedge clk);
        rd16(cnt, 16'hffff);
        power_down <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            wr16(16'hfffe);
            wr(tecb_pkg::ADDR_CTRL, {4'b0101, 1'(s), 3'h7});
            pulse(1'b1, 16'h0000);
            rd16(16'hffff - 16'(s), 16'hffff);
            pulse(1'b0, 16'h0000);
            rd16(16'hffff, 16'hffff);
            c0 = n_wake;
            pulse(1'b1, 16'h0004);
            rd16(16'hfffe, 16'hffff);
            chk(16'(n_wake - c0), 16'h0001);
            rd(tecb_pkg::ADDR_STAT, 8'h01, 8'h01);
            wr(tecb_pkg::ADDR_STAT, 8'h01);
            rd(tecb_pkg::ADDR_STAT, 8'h00, 8'h01);
        end
        power_down <= 1'b0;
        for (int s = 0; s < 2; s++)
        begin
            wr(tecb_pkg::ADDR_CTRL, 8'h00);
            pulse(1'(s == 0), 16'h0000);
            wr16(16'hfff8);
            wr(tecb_pkg::ADDR_CTRL, {4'b1101, 1'(s), 3'h0});
            repeat (20) @(posedge clk);
            rd16(16'hfff8, 16'hffff);
            c0 = n_ovf;
            pulse(1'(s), 16'd40);
            rd16(16'h0000, 16'h0000);
            chk(16'(cnt >= 16'hfff9 && cnt <= 16'hfffb), 16'h1);
            chk(16'(n_ovf - c0), 16'h0001);
            rd(tecb_pkg::ADDR_CTRL, {4'b1100, 1'(s), 3'h0}, 8'hff);
            pulse(1'(s), 16'd40);
            rd16(cnt, 16'hffff);
        end
        wr(tecb_pkg::ADDR_DIR, 8'h00);
        wr(tecb_pkg::ADDR_DATA, 8'h01);
        wr(tecb_pkg::ADDR_PFS, 8'h03);
        wr(tecb_pkg::ADDR_MISC, 8'h00);
        pins(4'b1101);
        sib(1'b0);
        pins(4'b1110);
        sib(1'b1);
        pins(4'b1110);
        wr(tecb_pkg::ADDR_MISC, 8'h01);
        sib(1'b1);
        pins(4'b1101);
        wr(tecb_pkg::ADDR_DATA, 8'h02);
        pins(4'b1100);
        wr(tecb_pkg::ADDR_DATA, 8'h01);
        wr(tecb_pkg::ADDR_DIR, 8'h01);
        pins(4'b0101);
        rd(tecb_pkg::ADDR_STAT, 8'h04, 8'h06);
        wr(tecb_pkg::ADDR_DIR, 8'h00);
        wr(tecb_pkg::ADDR_PFS, 8'h01);
        wr(tecb_pkg::ADDR_DATA, 8'h02);
        pins(4'b1101);
        test_done();
    end
endmodule

bind tecb_top tecb_sva u_tecb_sva (.*);
